/* dps_pot_ctrl.sv */
// Purpose: serial control of a two-channel 256-step potentiometer
// Assumes: sclk_i toggles with cs_n_i high only to clear the link reset; cs high >= 4 clk_i cycles
// Notes:   shift register lives on sclk_i, latches and pins on clk_i
`timescale 1ns/1ps

module dps_pot_ctrl (
  // system clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  // serial link
  input  wire logic                     sclk_i,
  input  wire logic                     cs_n_i,
  input  wire logic                     serial_in_i,
  output logic                          serial_out_o,
  output logic                          serial_out_oe_n_o,
  // shutdown
  input  wire logic                     power_down_n_i,
  output logic                          shutdown_o,
  // wiper latches
  output logic [dps_pkg::CODE_BITS-1:0] wiper_setting0_o,
  output logic [dps_pkg::CODE_BITS-1:0] wiper_setting1_o
);
  import dps_pkg::*;

  // link domain
  logic                 link_rst_n;
  logic [WORD_BITS-1:0] shift_register;
  logic                 out_bit;

  // system domain
  logic                 cs_n_s;
  logic                 cs_n_d;
  logic                 power_down_n_s;
  logic                 out_bit_s;
  logic                 load_pulse;
  logic                 channel_select_bit;
  logic                 spare_address_bit;
  logic [CODE_BITS-1:0] wiper_code;

  // link reset only takes effect on sclk edges; power-up needs a few edges
  dps_sync #(
    .RESET_VAL (1'b0)
  ) u_link_rst (
    .clk_i     (sclk_i),
    .reset_n_i (1'b1),
    .d_i       (reset_n_i),
    .q_o       (link_rst_n)
  );

  // ---------------------------------------------------------------------
  // link side: ten-stage delay line on the serial clock
  // ---------------------------------------------------------------------

  always_ff @(posedge sclk_i) begin
    if (!link_rst_n) begin
      shift_register <= SHIFT_RESET;
    end else if (!cs_n_i) begin
      shift_register <= {shift_register[WORD_BITS-2:0], serial_in_i};
    end
  end

  // bit leaving the top stage is the one shifted in ten edges before
  always_ff @(posedge sclk_i) begin
    if (!link_rst_n) begin
      out_bit <= PIN_IDLE;
    end else if (!cs_n_i) begin
      out_bit <= shift_register[WORD_BITS-1];
    end
  end

  // ---------------------------------------------------------------------
  // crossings into the system clock
  // ---------------------------------------------------------------------

  dps_sync #(
    .RESET_VAL (1'b1)
  ) u_cs_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (cs_n_i),
    .q_o       (cs_n_s)
  );

  dps_sync #(
    .RESET_VAL (1'b1)
  ) u_pd_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (power_down_n_i),
    .q_o       (power_down_n_s)
  );

  // out_bit only moves on sclk edges, so a level crossing suffices
  dps_sync #(
    .RESET_VAL (1'b1)
  ) u_out_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (out_bit),
    .q_o       (out_bit_s)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cs_n_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
    end
  end

  // the word is quiet once cs is high: sclk stands still until next frame
  assign load_pulse         = cs_n_s & ~cs_n_d;
  assign channel_select_bit = shift_register[CHAN_BIT];
  assign spare_address_bit  = shift_register[SPARE_BIT];
  assign wiper_code         = shift_register[CODE_BITS-1:0];

  // ---------------------------------------------------------------------
  // wiper_setting latches
  // ---------------------------------------------------------------------

  // spare_address_bit is kept for compatibility and plays no part in decode;
  // loads ignore power_down_n so codes can be staged during shutdown
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wiper_setting0_o <= WIPER_RESET;
    end else if (load_pulse && channel_select_bit == CHAN_FIRST) begin
      wiper_setting0_o <= wiper_code;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wiper_setting1_o <= WIPER_RESET;
    end else if (load_pulse && channel_select_bit == CHAN_SECOND) begin
      wiper_setting1_o <= wiper_code;
    end
  end

  // ---------------------------------------------------------------------
  // shutdown and open-drain output
  // ---------------------------------------------------------------------

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shutdown_o <= 1'b0;
    end else begin
      shutdown_o <= ~power_down_n_s;
    end
  end

  // pin only ever pulls low; a one or shutdown leaves it to the pull-up
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      serial_out_oe_n_o <= 1'b1;
    end else begin
      serial_out_oe_n_o <= ~(power_down_n_s & ~out_bit_s);
    end
  end

  assign serial_out_o = 1'b0;

  // ---------------------------------------------------------------------
  // assertions: link domain
  // ---------------------------------------------------------------------

  property p_shift_in;
    @(posedge sclk_i) disable iff (!link_rst_n)
    !cs_n_i |=> (shift_register[0] == $past(serial_in_i));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial_in bit not shifted into stage zero");

  property p_delay_line;
    @(posedge sclk_i) disable iff (!link_rst_n)
    !cs_n_i |=> (out_bit == $past(shift_register[WORD_BITS-1]));
  endproperty
  a_delay_line: assert property (p_delay_line)
    else $error("serial output bit is not the tenth previous bit");

  property p_ten_deep;
    @(posedge sclk_i) disable iff (!link_rst_n)
    (!cs_n_i) [*8] ##1 (!cs_n_i) [*3]
      |=> (out_bit == $past(serial_in_i, 11));
  endproperty
  a_ten_deep: assert property (p_ten_deep)
    else $error("delay line depth is not ten");

  property p_hold_cs_high;
    @(posedge sclk_i) disable iff (!link_rst_n)
    cs_n_i |=> $stable(shift_register);
  endproperty
  a_hold_cs_high: assert property (p_hold_cs_high)
    else $error("shift register moved while chip select was high");

  // ---------------------------------------------------------------------
  // assertions: system domain
  // ---------------------------------------------------------------------

  property p_load_latency;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(cs_n_i) ##1 cs_n_i |-> ##1 load_pulse;
  endproperty
  a_load_latency: assert property (p_load_latency)
    else $error("chip select rise did not load within two cycles");

  property p_load_first;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && !shift_register[CHAN_BIT]
      |=> (wiper_setting0_o == $past(shift_register[CODE_BITS-1:0]))
          && $stable(wiper_setting1_o);
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("address 00 did not load only the first latch");

  property p_load_second;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && shift_register[CHAN_BIT]
      |=> (wiper_setting1_o == $past(shift_register[CODE_BITS-1:0]))
          && $stable(wiper_setting0_o);
  endproperty
  a_load_second: assert property (p_load_second)
    else $error("address 01 did not load only the second latch");

  property p_one_channel;
    @(posedge clk_i) disable iff (!reset_n_i)
    $changed(wiper_setting0_o) |-> $stable(wiper_setting1_o);
  endproperty
  a_one_channel: assert property (p_one_channel)
    else $error("both latches changed on one word");

  property p_no_load_idle;
    @(posedge clk_i) disable iff (!reset_n_i)
    !load_pulse |=> $stable(wiper_setting0_o) && $stable(wiper_setting1_o);
  endproperty
  a_no_load_idle: assert property (p_no_load_idle)
    else $error("a latch changed without a chip select rise");

  property p_midscale;
    @(posedge clk_i)
    $rose(reset_n_i) |-> (wiper_setting0_o == WIPER_RESET)
                         && (wiper_setting1_o == WIPER_RESET);
  endproperty
  a_midscale: assert property (p_midscale)
    else $error("latches not at midscale after reset");

  property p_shutdown;
    @(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> (shutdown_o == !$past(power_down_n_s));
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown does not follow power_down_n");

  property p_sdo_off;
    @(posedge clk_i) disable iff (!reset_n_i)
    !power_down_n_s |=> serial_out_oe_n_o;
  endproperty
  a_sdo_off: assert property (p_sdo_off)
    else $error("serial_out driven during shutdown");

  property p_open_drain;
    @(posedge clk_i) disable iff (!reset_n_i)
    power_down_n_s |=> (serial_out_oe_n_o == $past(out_bit_s))
                       && (serial_out_o == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain drive does not match serial bit");

  property p_load_in_shutdown;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && !power_down_n_s && !shift_register[CHAN_BIT]
      |=> (wiper_setting0_o == $past(shift_register[CODE_BITS-1:0]));
  endproperty
  a_load_in_shutdown: assert property (p_load_in_shutdown)
    else $error("load refused during shutdown");

  property p_reset_values;
    @(posedge clk_i)
    !reset_n_i |=> (wiper_setting0_o == WIPER_RESET) && !shutdown_o
                   && serial_out_oe_n_o;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("outputs not at reset values");

  // ---------------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------------

  property p_cov_first;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && !channel_select_bit;
  endproperty
  c_cov_first: cover property (p_cov_first);

  property p_cov_second;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && channel_select_bit;
  endproperty
  c_cov_second: cover property (p_cov_second);

  property p_cov_shutdown_load;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && !power_down_n_s;
  endproperty
  c_cov_shutdown_load: cover property (p_cov_shutdown_load);

  property p_cov_drive_low;
    @(posedge clk_i) disable iff (!reset_n_i)
    !serial_out_oe_n_o;
  endproperty
  c_cov_drive_low: cover property (p_cov_drive_low);

  property p_cov_spare;
    @(posedge clk_i) disable iff (!reset_n_i)
    load_pulse && spare_address_bit;
  endproperty
  c_cov_spare: cover property (p_cov_spare);

endmodule : dps_pot_ctrl

/* dps_pkg.sv */
// Purpose: constants for the dual potentiometer serial control block
// Assumes: ten-bit command words, two wiper_setting latches
// Notes:   shared by dps_pot_ctrl and dps_pot_ctrl_tb_top
//
// Operation
// - ten-bit word: two address bits, eight-bit code
// - shift serial_in on rising sclk, cs low
// - serial_out repeats bit from ten shifts earlier
// - clock low, cs low: register holds, output enabled
// - cs rise loads selected latch, clock ignored
// - address 00 first latch, 01 second latch
// - only ten latest bits used at cs rise
// - final eight shifted bits become wiper_code
// - each word updates exactly one channel
// - both latches midscale at power-on
// - power_down_n low asserts shutdown for both channels
// - power_down_n low releases serial_out driver
// - shutdown clears neither latch; cs rise still loads one
// - serial_out open drain: pull low for zero

package dps_pkg;

  localparam int WORD_BITS = 10;
  localparam int CODE_BITS = 8;
  localparam int CHAN_BIT  = 8;
  localparam int SPARE_BIT = 9;

  localparam logic [CODE_BITS-1:0] WIPER_RESET = 8'h80;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 10'h000;
  localparam logic                 CHAN_FIRST  = 1'b0;
  localparam logic                 CHAN_SECOND = 1'b1;
  localparam logic                 PIN_IDLE    = 1'b1;

endpackage : dps_pkg

/* dps_sync.sv */
// Purpose: two-flop level synchroniser
// Assumes: input is a slowly changing level
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps

module dps_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : dps_sync

/* dps_host_model.sv */
// Purpose: host side of the three-wire link, drives frames into the block
// Assumes: link clock 125 ns period, also runs with cs high to clear the link-side reset
// Notes:   rx collects the pin level seen after every shift, msb first
`timescale 1ns/1ps

module dps_host_model (
  // bench clock
  input  wire logic clk_i,
  // serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i
);
  logic [19:0] rx;

  initial begin
    sclk_o      = 1'b0;
    cs_n_o      = 1'b1;
    serial_in_o = 1'b0;
    rx          = 20'h00000;
  end

  // edges with cs high are ignored, they only clear the link-side reset
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
  endtask : idle_clocks

  // one frame, msb first, single clean edge per half period
  task automatic send(input logic [19:0] bits, input int n);
    @(negedge clk_i) cs_n_o = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      #17.3 serial_in_o = bits[k];
      #45.2 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
      rx = {rx[18:0], serial_out_i};
    end
    #30;
    @(negedge clk_i) cs_n_o = 1'b1;
    // line flips once the frame ends, so no stale bit is mistaken for data
    serial_in_o = ~serial_in_o;
  endtask : send
endmodule : dps_host_model

/* dps_pot_ctrl_tb_top.sv */
// Purpose: self-checking bench for the potentiometer serial control
// Assumes: wiper outputs settle within 4 clk_i cycles of cs rising
// Notes:   reset held until 3 link edges pass, so the shift register clears
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end

module dps_pot_ctrl_tb_top;
  import dps_pkg::*;
  typedef struct packed {
    logic [9:0] w;
    logic [7:0] e0;
    logic [7:0] e1;
  } dps_row_t;

  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       power_down_n = 1'b1;
  logic       sclk, cs_n, ser_in, ser_out, ser_out_oe_n, shutdown;
  logic [7:0] w0, w1;
  wire logic  pin = ser_out_oe_n ? 1'b1 : ser_out;
  int         bad_count = 0;
  int         compares = 0;
  dps_row_t   rows [5] = '{
    '{10'h0a5, 8'ha5, 8'h80},
    '{10'h13c, 8'ha5, 8'h3c},
    '{10'h0ff, 8'hff, 8'h3c},
    '{10'h100, 8'hff, 8'h00},
    '{10'h211, 8'h11, 8'h00}
  };

  always #2.5 clk = ~clk;

  dps_pot_ctrl dps_pot_ctrl_i (
    .clk_i             (clk),
    .reset_n_i         (reset_n),
    .sclk_i            (sclk),
    .cs_n_i            (cs_n),
    .serial_in_i       (ser_in),
    .serial_out_o      (ser_out),
    .serial_out_oe_n_o (ser_out_oe_n),
    .power_down_n_i    (power_down_n),
    .shutdown_o        (shutdown),
    .wiper_setting0_o  (w0),
    .wiper_setting1_o  (w1)
  );

  dps_host_model dps_host_model_i (
    .clk_i        (clk),
    .sclk_o       (sclk),
    .cs_n_o       (cs_n),
    .serial_in_o  (ser_in),
    .serial_out_i (pin)
  );

  task automatic print_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_shutdown(input logic lvl);
    int n;
    n = 0;
    while (shutdown !== lvl) begin
      n++;
      if (n > 8) begin
        bad_count++;
        print_verdict();
      end
      @(negedge clk);
    end
  endtask : wait_shutdown

  task automatic frame(input logic [19:0] bits, input int n);
    dps_host_model_i.send(bits, n);
    repeat (4) @(negedge clk);
  endtask : frame

  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end

  initial begin
    dps_host_model_i.idle_clocks(3);
    @(negedge clk) reset_n = 1'b1;
    // link reset only leaves on sclk edges; else frame one loses two bits
    dps_host_model_i.idle_clocks(3);
    repeat (4) @(negedge clk);
    `CHK("w0 reset", 8'h80, w0)
    `CHK("w1 reset", 8'h80, w1)
    `CHK("shutdown reset", 1'b0, shutdown)
    // channels in mixed order, one word each
    foreach (rows[i]) begin
      frame({10'h000, rows[i].w}, 10);
      `CHK("w0 row", rows[i].e0, w0)
      `CHK("w1 row", rows[i].e1, w1)
    end
    // chained frame: first word passes through, second one is kept
    frame({10'h0c2, 10'h15a}, 20);
    `CHK("pin delay line", {10'h211, 10'h0c2}, dps_host_model_i.rx)
    `CHK("w1 last ten", 8'h5a, w1)
    `CHK("w0 untouched", 8'h11, w0)
    `CHK("pin driven low", 1'b0, pin)
    @(negedge clk) power_down_n = 1'b0;
    wait_shutdown(1'b1);
    `CHK("shutdown on", 1'b1, shutdown)
    `CHK("pin released", 1'b1, pin)
    frame({10'h000, 10'h033}, 10);
    `CHK("w0 load in shutdown", 8'h33, w0)
    `CHK("w1 kept", 8'h5a, w1)
    @(negedge clk) power_down_n = 1'b1;
    wait_shutdown(1'b0);
    repeat (2) @(negedge clk);
    `CHK("shutdown off", 1'b0, shutdown)
    `CHK("w0 resumes", 8'h33, w0)
    `CHK("pin driven again", 1'b0, pin)
    // mid-run reset brings both latches back to midscale
    @(negedge clk) reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    `CHK("w0 reset again", 8'h80, w0)
    `CHK("w1 reset again", 8'h80, w1)
    print_verdict();
  end
endmodule : dps_pot_ctrl_tb_top
